// ### include/bru_pkg.sv
// Shared constants and types for the branch instruction unit.
// Assumes 16-bit instruction words and 32-bit addresses in the core clock domain.
package bru_pkg;
    // Opcode fields of the branch group
    localparam logic [3:0]  BRU_OP_REL_JUMP     = 4'hA;
    localparam logic [3:0]  BRU_OP_REL_CALL     = 4'hB;
    localparam logic [3:0]  BRU_OP_SYS          = 4'h0;
    localparam logic [3:0]  BRU_OP_SYS4         = 4'h4;
    localparam logic [7:0]  BRU_OP_JUMP_IF_SET  = 8'h89;
    localparam logic [7:0]  BRU_OP_JUMP_IF_CLR  = 8'h8B;
    localparam logic [7:0]  BRU_OP_DJUMP_IF_SET = 8'h8D;
    localparam logic [7:0]  BRU_OP_DJUMP_IF_CLR = 8'h8F;
    localparam logic [7:0]  BRU_LO_REG_JUMP     = 8'h23;
    localparam logic [7:0]  BRU_LO_REG_CALL     = 8'h03;
    localparam logic [7:0]  BRU_LO_ABS_JUMP     = 8'h2B;
    localparam logic [7:0]  BRU_LO_ABS_CALL     = 8'h0B;
    // Address arithmetic
    localparam logic [31:0] BRU_PC_OFFSET       = 32'h0000_0004;
    localparam logic [31:0] BRU_SLOT_OFFSET     = 32'h0000_0002;
    localparam logic [31:0] BRU_ADDR_RESET      = 32'h0000_0000;

    typedef enum logic [1:0] {
        BRU_CLS_REL12 = 2'b00,
        BRU_CLS_REG   = 2'b01,
        BRU_CLS_REL8  = 2'b10
    } bru_cls_t;

    typedef enum logic {
        BRU_ST_IDLE = 1'b0,
        BRU_ST_SLOT = 1'b1
    } bru_state_t;
endpackage

// ### design/bru_target_calc.sv
// Branch target adder: instruction address plus 4 plus a displacement or register.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bru_target_calc
    import bru_pkg::*;
(
    // Instruction
    input  wire logic [31:0] instAddr,
    input  wire logic [15:0] instWord,
    input  wire bru_cls_t    cls,
    // Register operand
    input  wire logic [31:0] regValue,
    // Result
    output logic      [31:0] target
);
    logic [31:0] offset;

    always_comb
    begin
        unique case (cls)
            BRU_CLS_REL12: offset = {{19{instWord[11]}}, instWord[11:0], 1'b0};
            BRU_CLS_REL8:  offset = {{23{instWord[7]}}, instWord[7:0], 1'b0};
            BRU_CLS_REG:   offset = regValue;
            default:       offset = 32'h0000_0000;
        endcase
    end

    // Wraps modulo 2^32 like the program counter itself
    assign target = instAddr + BRU_PC_OFFSET + offset;
endmodule

// ### design/branch_instruction_unit.sv
// Branch instruction unit: decodes and executes relative, register-relative,
// call and jump-if-set flag branches, and tracks the delay slot.
// Assumes the core presents one instruction per instValid pulse with the
// selected register value in the same cycle, all on clk.
`timescale 1ns/1ps
module branch_instruction_unit
    import bru_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Instruction from the decode stage
    input  wire logic        instValid,
    input  wire logic [15:0] instWord,
    input  wire logic [31:0] instAddr,
    input  wire logic        condFlag,
    // General register file read
    output logic      [3:0]  selRegIndex,
    input  wire logic [31:0] selRegValue,
    // Program counter redirect
    output logic             pcLoad,
    output logic      [31:0] newPc,
    // Procedure return register write
    output logic             retWrite,
    output logic      [31:0] retValue,
    // Delay slot control
    output logic             slotFetchReq,
    output logic      [31:0] slotFetchAddr,
    output logic             slotIllegal,
    output logic             irqBlock
);
    bru_state_t  state_ff, nxt_state;
    logic [31:0] pendTarget_ff, nxt_pendTarget;
    logic [31:0] newPc_ff, nxt_newPc;
    logic        pcLoad_ff, nxt_pcLoad;
    logic        retWrite_ff, nxt_retWrite;
    logic [31:0] retValue_ff, nxt_retValue;
    logic        slotReq_ff, nxt_slotReq;
    logic [31:0] slotAddr_ff, nxt_slotAddr;
    logic        slotIll_ff, nxt_slotIll;

    logic        isRelJump, isRelCall, isRegJump, isRegCall, isJumpIfSet;
    logic        isDelayed, isAnyBranch;
    bru_cls_t    cls;
    logic [31:0] target;

    // Decode
    assign isRelJump   = instWord[15:12] == BRU_OP_REL_JUMP;
    assign isRelCall   = instWord[15:12] == BRU_OP_REL_CALL;
    assign isRegJump   = instWord[15:12] == BRU_OP_SYS && instWord[7:0] == BRU_LO_REG_JUMP;
    assign isRegCall   = instWord[15:12] == BRU_OP_SYS && instWord[7:0] == BRU_LO_REG_CALL;
    assign isJumpIfSet = instWord[15:8] == BRU_OP_JUMP_IF_SET;
    assign isDelayed   = isRelJump | isRelCall | isRegJump | isRegCall;
    // Slot check covers the whole branch family, including forms not executed here
    assign isAnyBranch = isDelayed | isJumpIfSet
                       | instWord[15:8] == BRU_OP_JUMP_IF_CLR
                       | instWord[15:8] == BRU_OP_DJUMP_IF_SET
                       | instWord[15:8] == BRU_OP_DJUMP_IF_CLR
                       | (instWord[15:12] == BRU_OP_SYS4
                          && (instWord[7:0] == BRU_LO_ABS_JUMP || instWord[7:0] == BRU_LO_ABS_CALL));

    assign cls = (isRegJump | isRegCall) ? BRU_CLS_REG
               : isJumpIfSet ? BRU_CLS_REL8 : BRU_CLS_REL12;

    assign selRegIndex = instWord[11:8];

    bru_target_calc u_target (
        .instAddr (instAddr),
        .instWord (instWord),
        .cls      (cls),
        .regValue (selRegValue),
        .target   (target)
    );

    always_comb
    begin
        nxt_state      = state_ff;
        nxt_pendTarget = pendTarget_ff;
        nxt_newPc      = newPc_ff;
        nxt_pcLoad     = 1'b0;
        nxt_retWrite   = 1'b0;
        nxt_retValue   = retValue_ff;
        nxt_slotReq    = 1'b0;
        nxt_slotAddr   = slotAddr_ff;
        nxt_slotIll    = 1'b0;
        unique case (state_ff)
            BRU_ST_IDLE:
            begin
                if (instValid && isDelayed)
                begin
                    // Target held back until the slot has run
                    nxt_pendTarget = target;
                    nxt_slotAddr   = instAddr + BRU_SLOT_OFFSET;
                    nxt_slotReq    = 1'b1;
                    nxt_state      = BRU_ST_SLOT;
                    if (isRelCall || isRegCall)
                    begin
                        nxt_retWrite = 1'b1;
                        nxt_retValue = instAddr + BRU_PC_OFFSET;
                    end
                end
                else if (instValid && isJumpIfSet)
                begin
                    nxt_pcLoad = 1'b1;
                    nxt_newPc  = condFlag ? target : instAddr + BRU_SLOT_OFFSET;
                end
            end
            BRU_ST_SLOT:
            begin
                if (instValid)
                begin
                    nxt_state = BRU_ST_IDLE;
                    if (isAnyBranch)
                        nxt_slotIll = 1'b1;
                    else
                    begin
                        nxt_pcLoad = 1'b1;
                        nxt_newPc  = pendTarget_ff;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff      <= BRU_ST_IDLE;
            pendTarget_ff <= BRU_ADDR_RESET;
            newPc_ff      <= BRU_ADDR_RESET;
            pcLoad_ff     <= 1'b0;
            retWrite_ff   <= 1'b0;
            retValue_ff   <= BRU_ADDR_RESET;
            slotReq_ff    <= 1'b0;
            slotAddr_ff   <= BRU_ADDR_RESET;
            slotIll_ff    <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            pendTarget_ff <= nxt_pendTarget;
            newPc_ff      <= nxt_newPc;
            pcLoad_ff     <= nxt_pcLoad;
            retWrite_ff   <= nxt_retWrite;
            retValue_ff   <= nxt_retValue;
            slotReq_ff    <= nxt_slotReq;
            slotAddr_ff   <= nxt_slotAddr;
            slotIll_ff    <= nxt_slotIll;
        end
    end

    assign pcLoad        = pcLoad_ff;
    assign newPc         = newPc_ff;
    assign retWrite      = retWrite_ff;
    assign retValue      = retValue_ff;
    assign slotFetchReq  = slotReq_ff;
    assign slotFetchAddr = slotAddr_ff;
    assign slotIllegal   = slotIll_ff;
    // Blocks from the branch's own cycle so no interrupt slips in before the slot
    assign irqBlock = (state_ff == BRU_ST_SLOT) || (instValid && isDelayed);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [31:0] chkDisp12, chkDisp8;
    assign chkDisp12 = {{19{instWord[11]}}, instWord[11:0], 1'b0};
    assign chkDisp8  = {{23{instWord[7]}}, instWord[7:0], 1'b0};

    sequence s_delayedTaken;
        state_ff == BRU_ST_IDLE && instValid && isDelayed;
    endsequence

    sequence s_slotRuns;
        state_ff == BRU_ST_SLOT && instValid && !isAnyBranch;
    endsequence

    property p_relJump;
        state_ff == BRU_ST_IDLE && instValid && instWord[15:12] == 4'hA
        |=> state_ff == BRU_ST_SLOT && !pcLoad
            && pendTarget_ff == $past(instAddr) + 32'h4 + $past(chkDisp12);
    endproperty
    a_relJump: assert property (p_relJump) else $error("relative jump target wrong");

    property p_slotFirst;
        logic [31:0] t;
        (s_slotRuns, t = pendTarget_ff) |=> pcLoad && newPc == t && state_ff == BRU_ST_IDLE;
    endproperty
    a_slotFirst: assert property (p_slotFirst) else $error("slot did not precede target");

    property p_irqHeld;
        s_delayedTaken |-> irqBlock ##1 (irqBlock throughout (state_ff == BRU_ST_SLOT));
    endproperty
    a_irqHeld: assert property (p_irqHeld) else $error("interrupt window opened in slot");

    property p_slotIllegal;
        state_ff == BRU_ST_SLOT && instValid && isAnyBranch |=> slotIllegal && !pcLoad ##1 !slotIllegal;
    endproperty
    a_slotIllegal: assert property (p_slotIllegal) else $error("branch in slot not flagged");

    property p_regJump;
        state_ff == BRU_ST_IDLE && instValid && instWord[15:12] == 4'h0 && instWord[7:0] == 8'h23
        |=> pendTarget_ff == $past(instAddr) + 32'h4 + $past(selRegValue) && !retWrite;
    endproperty
    a_regJump: assert property (p_regJump) else $error("register jump target wrong");

    property p_relCall;
        state_ff == BRU_ST_IDLE && instValid && instWord[15:12] == 4'hB
        |=> retWrite && retValue == $past(instAddr) + 32'h4
            && pendTarget_ff == $past(instAddr) + 32'h4 + $past(chkDisp12);
    endproperty
    a_relCall: assert property (p_relCall) else $error("relative call wrong");

    property p_regCall;
        state_ff == BRU_ST_IDLE && instValid && instWord[15:12] == 4'h0 && instWord[7:0] == 8'h03
        |=> retWrite && retValue == $past(instAddr) + 32'h4
            && pendTarget_ff == $past(instAddr) + 32'h4 + $past(selRegValue);
    endproperty
    a_regCall: assert property (p_regCall) else $error("register call wrong");

    property p_jumpIfSet;
        state_ff == BRU_ST_IDLE && instValid && instWord[15:8] == 8'h89
        |=> pcLoad && newPc == ($past(condFlag) ? $past(instAddr) + 32'h4 + $past(chkDisp8)
                                                : $past(instAddr) + 32'h2);
    endproperty
    a_jumpIfSet: assert property (p_jumpIfSet) else $error("conditional jump wrong");

    property p_slotAddr;
        s_delayedTaken |=> slotFetchReq && slotFetchAddr == $past(instAddr) + 32'h2 ##1 !slotFetchReq;
    endproperty
    a_slotAddr: assert property (p_slotAddr) else $error("slot fetch address wrong");
endmodule

// ### verif/branch_instruction_unit_tb.sv
// Self-checking bench for the branch instruction unit.
// Assumes the unit's pulses land just after the taking edge and irqBlock is combinational.
`timescale 1ns/1ps
module branch_instruction_unit_tb;
    logic        clk;
    logic        reset_n;
    logic        instValid;
    logic [15:0] instWord;
    logic [31:0] instAddr;
    logic        condFlag;
    logic [3:0]  selRegIndex;
    logic [31:0] selRegValue;
    logic        pcLoad;
    logic [31:0] newPc;
    logic        retWrite;
    logic [31:0] retValue;
    logic        slotFetchReq;
    logic [31:0] slotFetchAddr;
    logic        slotIllegal;
    logic        irqBlock;
    logic        irqNow;
    logic [3:0]  selNow;
    logic [3:0]  selBranch;
    int          err_total;
    int          tests_run;
    int          cycles;

    branch_instruction_unit u_branch_instruction_unit (
        .clk          (clk),
        .reset_n      (reset_n),
        .instValid    (instValid),
        .instWord     (instWord),
        .instAddr     (instAddr),
        .condFlag     (condFlag),
        .selRegIndex  (selRegIndex),
        .selRegValue  (selRegValue),
        .pcLoad       (pcLoad),
        .newPc        (newPc),
        .retWrite     (retWrite),
        .retValue     (retValue),
        .slotFetchReq (slotFetchReq),
        .slotFetchAddr(slotFetchAddr),
        .slotIllegal  (slotIllegal),
        .irqBlock     (irqBlock)
    );

    always #12.5 clk = ~clk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Generous ceiling; the full sequence needs well under a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // One instruction for one cycle; instWord, instAddr and selRegValue then show inverted values, condFlag keeps its value
    task automatic issue(input logic [15:0] w, input logic [31:0] a, input logic f, input logic [31:0] r);
        @(posedge clk);
        instValid   <= 1'b1;
        instWord    <= w;
        instAddr    <= a;
        condFlag    <= f;
        selRegValue <= r;
        #1;
        irqNow = irqBlock;
        selNow = selRegIndex;
        @(posedge clk);
        instValid   <= 1'b0;
        instWord    <= ~w;
        instAddr    <= ~a;
        selRegValue <= ~r;
        #1;
    endtask

    task automatic delayed(input logic [15:0] w, input logic [31:0] a, input logic [31:0] r,
                           input logic [31:0] tgt, input logic call, input logic [15:0] slotw,
                           input logic ill, input int gap);
        issue(w, a, 1'b0, r);
        // Slot issue overwrites selNow, so keep the branch cycle's register field
        selBranch = selNow;
        chk("irqBlock in branch cycle", 1, irqNow);
        chk("slotFetchReq", 1, slotFetchReq);
        chk("slotFetchAddr", a + 32'h0000_0002, slotFetchAddr);
        chk("retWrite", call, retWrite);
        if (call)
            chk("retValue", a + 32'h0000_0004, retValue);
        chk("pcLoad before slot", 0, pcLoad);
        repeat (gap)
        begin
            @(posedge clk);
            #1;
            chk("irqBlock awaiting slot", 1, irqBlock);
        end
        issue(slotw, a + 32'h0000_0002, 1'b0, 32'h0000_0000);
        chk("irqBlock in slot cycle", 1, irqNow);
        chk("pcLoad after slot", !ill, pcLoad);
        if (!ill)
            chk("newPc", tgt, newPc);
        chk("slotIllegal", ill, slotIllegal);
        chk("irqBlock after slot", 0, irqBlock);
    endtask

    task automatic flag_jump(input logic f, input logic [31:0] tgt);
        issue(16'h8980, 32'h0000_6000, f, 32'h0000_0000);
        chk("irqBlock plain jump", 0, irqNow);
        chk("pcLoad flag jump", 1, pcLoad);
        chk("newPc flag jump", tgt, newPc);
        chk("slotFetchReq plain jump", 0, slotFetchReq);
    endtask

    // Most negative and most positive displacements, first slot after a two-cycle gap
    task automatic rel_forms();
        delayed(16'hA800, 32'h0000_1000, 32'h0000_0000, 32'h0000_0004, 1'b0, 16'h0009, 1'b0, 2);
        delayed(16'hB7FF, 32'h0000_2000, 32'h0000_0000, 32'h0000_3002, 1'b1, 16'h0009, 1'b0, 0);
    endtask

    // A jump and a call, each with a branch word in its slot
    task automatic slot_branch();
        delayed(16'hA010, 32'h0000_5000, 32'h0000_0000, 32'h0000_0000, 1'b0, 16'hB000, 1'b1, 0);
        delayed(16'hB010, 32'h0000_5100, 32'h0000_0000, 32'h0000_0000, 1'b1, 16'h8D05, 1'b1, 0);
    endtask

    task automatic reg_forms();
        delayed(16'h0523, 32'hFFFF_FFF0, 32'h0000_0020, 32'h0000_0014, 1'b0, 16'h0009, 1'b0, 0);
        chk("selRegIndex", 4'h5, selBranch);
        delayed(16'h0A03, 32'h0000_4000, 32'hFFFF_F000, 32'h0000_3004, 1'b1, 16'h0009, 1'b0, 1);
        chk("selRegIndex call", 4'hA, selBranch);
    endtask

    task automatic idle_other();
        issue(16'h0009, 32'h0000_7000, 1'b1, 32'h0000_0000);
        chk("pcLoad on non-branch", 0, pcLoad);
        chk("irqBlock on non-branch", 0, irqNow);
    endtask

    initial
    begin
        clk         = 1'b0;
        reset_n     = 1'b0;
        instValid   = 1'b0;
        instWord    = 16'h0000;
        instAddr    = 32'h0000_0000;
        condFlag    = 1'b0;
        selRegValue = 32'h0000_0000;
        err_total   = 0;
        tests_run   = 0;
        cycles      = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        chk("pcLoad in reset", 0, pcLoad);
        rel_forms();
        reg_forms();
        slot_branch();
        flag_jump(1'b1, 32'h0000_5F04);
        flag_jump(1'b0, 32'h0000_6002);
        idle_other();
        stop_test();
    end
endmodule
